// [src/ctdp_params.svh]
`ifndef CTDP_PARAMS_SVH
`define CTDP_PARAMS_SVH

// Register addresses
`define CTDP_ADDR_PORT0 8'h80
`define CTDP_ADDR_SP 8'h81
`define CTDP_ADDR_PA_LO 8'h82
`define CTDP_ADDR_PA_HI 8'h83
`define CTDP_ADDR_PB_LO 8'h84
`define CTDP_ADDR_PB_HI 8'h85
`define CTDP_ADDR_SEL 8'h86
`define CTDP_ADDR_POWER_CONTROL 8'h87
`define CTDP_ADDR_TIMER_CONTROL 8'h88
`define CTDP_ADDR_TIMER_MODE_SELECT 8'h89
`define CTDP_ADDR_TA_LO 8'h8A
`define CTDP_ADDR_TB_LO 8'h8B
`define CTDP_ADDR_TA_HI 8'h8C
`define CTDP_ADDR_TB_HI 8'h8D
`define CTDP_ADDR_CLOCK_RATE_CONTROL 8'h8E

// Field positions
`define CTDP_SEL_BIT 0
`define CTDP_STRETCH_LSB 0
`define CTDP_RATE_LSB 3

// Fixed bits of the power control register
`define CTDP_POWER_CONTROL_ONES 8'h30

// Reset values
`define CTDP_RST_PORT0 8'hFF
`define CTDP_RST_SP 8'h07
`define CTDP_RST_POWER_CONTROL 8'h30
`define CTDP_RST_CLOCK_RATE_CONTROL 8'h01
`define CTDP_RST_ZERO 8'h00

// Timing counts in core clocks or instruction cycles
`define CTDP_CLK_PER_CYC 4
`define CTDP_SLOW_DIV 12
`define CTDP_FAST_DIV 4
`define CTDP_XMOVE_BASE 2
`define CTDP_MULDIV_CYC 5
`define CTDP_MAX_CYC 5

`endif

// [src/ctdp_pkg.sv]
package ctdp_pkg;

  typedef enum logic [1:0] {
    CTDP_ST_IDLE = 2'b01,
    CTDP_ST_EXEC = 2'b10
  } ctdp_state_t;

  typedef enum logic [1:0] {
    CTDP_CLS_BYTES = 2'h0,
    CTDP_CLS_XMOVE = 2'h1,
    CTDP_CLS_MULDIV = 2'h2
  } ctdp_class_t;

  typedef enum logic [1:0] {
    CTDP_PTR_NONE = 2'h0,
    CTDP_PTR_LOAD = 2'h1,
    CTDP_PTR_INC = 2'h2,
    CTDP_PTR_INDEX = 2'h3
  } ctdp_ptr_op_t;

endpackage : ctdp_pkg

// [src/ctdp_rate_div.sv]
`timescale 1ns/10ps
`default_nettype none

module ctdp_rate_div #(
  parameter int SLOW = 12,
  parameter int FAST = 4
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Rate control
  input wire logic fast_i,
  // Increment strobe
  output logic tick_o
);

  logic [3:0] cnt;
  wire [3:0] lim_last = fast_i ? 4'(FAST - 1) : 4'(SLOW - 1);
  // A rate change mid-count never strands the counter past its limit
  wire at_end = (cnt >= lim_last);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      cnt <= at_end ? 4'h0 : cnt + 4'h1;
      tick_o <= at_end;
    end
  end

endmodule : ctdp_rate_div

`default_nettype wire

// [src/ctdp_core.sv]
`include "ctdp_params.svh"
`timescale 1ns/10ps
`default_nettype none

module ctdp_core
  import ctdp_pkg::*;
#(
  parameter int SLOW_DIV = `CTDP_SLOW_DIV,
  parameter int FAST_DIV = `CTDP_FAST_DIV,
  parameter int MULDIV_CYC = `CTDP_MULDIV_CYC,
  parameter int NUM_TIMERS = 3
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register access from the core
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // Instruction timing
  input wire logic instr_start_i,
  input wire ctdp_class_t instr_class_i,
  input wire logic [2:0] instr_bytes_i,
  output logic instr_ready_o,
  output logic instr_done_o,
  output logic instr_busy_o,
  output logic cycle_strobe_o,
  output logic [1:0] phase_o,
  // Data pointer operations
  input wire ctdp_ptr_op_t ptr_op_i,
  input wire logic [15:0] ptr_load_i,
  input wire logic [7:0] acc_i,
  output logic [15:0] active_data_pointer_o,
  output logic [15:0] index_addr_o,
  // Timer increment strobes
  output logic [NUM_TIMERS-1:0] timer_tick_o,
  // Register contents for neighbouring logic
  output logic [7:0] port0_latch_o,
  output logic [7:0] stack_pointer_o,
  output logic [7:0] power_control_o,
  output logic [7:0] timer_control_o,
  output logic [7:0] timer_mode_select_o
);

  localparam logic [1:0] PH_LAST = 2'(`CTDP_CLK_PER_CYC - 1);

  // Register storage
  logic [7:0] port0_latch;
  logic [7:0] stack_pointer;
  logic [7:0] first_pointer_low;
  logic [7:0] first_pointer_high;
  logic [7:0] second_pointer_low;
  logic [7:0] second_pointer_high;
  logic pointer_select;
  logic [7:0] power_control;
  logic [7:0] timer_control;
  logic [7:0] timer_mode_select;
  logic [7:0] timer_a_count_low;
  logic [7:0] timer_b_count_low;
  logic [7:0] timer_a_count_high;
  logic [7:0] timer_b_count_high;
  logic [7:0] clock_rate_control;

  // Timing state
  logic [1:0] phase;
  ctdp_state_t state;
  ctdp_state_t next_state;
  logic [3:0] cycles_left;
  logic [3:0] next_cycles_left;

  // Pointer next values
  logic [15:0] next_first;
  logic [15:0] next_second;
  logic next_sel;

  // Address decode
  wire hit_port0 = (sfr_addr_i == `CTDP_ADDR_PORT0);
  wire hit_sp = (sfr_addr_i == `CTDP_ADDR_SP);
  wire hit_pa_lo = (sfr_addr_i == `CTDP_ADDR_PA_LO);
  wire hit_pa_hi = (sfr_addr_i == `CTDP_ADDR_PA_HI);
  wire hit_pb_lo = (sfr_addr_i == `CTDP_ADDR_PB_LO);
  wire hit_pb_hi = (sfr_addr_i == `CTDP_ADDR_PB_HI);
  wire hit_sel = (sfr_addr_i == `CTDP_ADDR_SEL);
  wire hit_power_control = (sfr_addr_i == `CTDP_ADDR_POWER_CONTROL);
  wire hit_timer_control = (sfr_addr_i == `CTDP_ADDR_TIMER_CONTROL);
  wire hit_timer_mode_select = (sfr_addr_i == `CTDP_ADDR_TIMER_MODE_SELECT);
  wire hit_ta_lo = (sfr_addr_i == `CTDP_ADDR_TA_LO);
  wire hit_tb_lo = (sfr_addr_i == `CTDP_ADDR_TB_LO);
  wire hit_ta_hi = (sfr_addr_i == `CTDP_ADDR_TA_HI);
  wire hit_tb_hi = (sfr_addr_i == `CTDP_ADDR_TB_HI);
  wire hit_clock_rate_control = (sfr_addr_i == `CTDP_ADDR_CLOCK_RATE_CONTROL);

  // Unassigned addresses neither store nor answer
  wire any_hit = hit_port0 | hit_sp | hit_pa_lo | hit_pa_hi | hit_pb_lo
    | hit_pb_hi | hit_sel | hit_power_control | hit_timer_control | hit_timer_mode_select | hit_ta_lo
    | hit_tb_lo | hit_ta_hi | hit_tb_hi | hit_clock_rate_control;

  assign sfr_hit_o = any_hit;

  // Write strobes
  wire wr_port0 = sfr_wr_i & hit_port0;
  wire wr_sp = sfr_wr_i & hit_sp;
  wire wr_pa_lo = sfr_wr_i & hit_pa_lo;
  wire wr_pa_hi = sfr_wr_i & hit_pa_hi;
  wire wr_pb_lo = sfr_wr_i & hit_pb_lo;
  wire wr_pb_hi = sfr_wr_i & hit_pb_hi;
  wire wr_sel = sfr_wr_i & hit_sel;
  wire wr_power_control = sfr_wr_i & hit_power_control;
  wire wr_timer_control = sfr_wr_i & hit_timer_control;
  wire wr_timer_mode_select = sfr_wr_i & hit_timer_mode_select;
  wire wr_ta_lo = sfr_wr_i & hit_ta_lo;
  wire wr_tb_lo = sfr_wr_i & hit_tb_lo;
  wire wr_ta_hi = sfr_wr_i & hit_ta_hi;
  wire wr_tb_hi = sfr_wr_i & hit_tb_hi;
  wire wr_clock_rate_control = sfr_wr_i & hit_clock_rate_control;

  // Read views with constant bits forced
  wire [7:0] sel_view = {7'h00, pointer_select};
  wire [7:0] power_control_view = power_control | `CTDP_POWER_CONTROL_ONES;

  wire [7:0] read_mux =
    hit_port0 ? port0_latch :
    hit_sp ? stack_pointer :
    hit_pa_lo ? first_pointer_low :
    hit_pa_hi ? first_pointer_high :
    hit_pb_lo ? second_pointer_low :
    hit_pb_hi ? second_pointer_high :
    hit_sel ? sel_view :
    hit_power_control ? power_control_view :
    hit_timer_control ? timer_control :
    hit_timer_mode_select ? timer_mode_select :
    hit_ta_lo ? timer_a_count_low :
    hit_tb_lo ? timer_b_count_low :
    hit_ta_hi ? timer_a_count_high :
    hit_tb_hi ? timer_b_count_high :
    hit_clock_rate_control ? clock_rate_control :
    8'h00;

  // Clock control fields
  wire [2:0] stretch = clock_rate_control[`CTDP_STRETCH_LSB +: 3];
  wire [2:0] rate_bits = clock_rate_control[`CTDP_RATE_LSB +: 3];

  // Cycle count per instruction class
  wire [3:0] bytes_ext = {1'b0, instr_bytes_i};
  wire [3:0] bytes_cyc =
    (bytes_ext == 4'h0) ? 4'h1 :
    (bytes_ext > 4'(`CTDP_MAX_CYC)) ? 4'(`CTDP_MAX_CYC) :
    bytes_ext;
  wire [3:0] xmove_cyc = 4'(`CTDP_XMOVE_BASE) + {1'b0, stretch};
  wire [3:0] muldiv_cyc = 4'(MULDIV_CYC);
  wire [3:0] req_cyc =
    (instr_class_i == CTDP_CLS_XMOVE) ? xmove_cyc :
    (instr_class_i == CTDP_CLS_MULDIV) ? muldiv_cyc :
    bytes_cyc;

  // Sequencer handshake
  wire cyc_end = (phase == PH_LAST);
  wire in_exec = (state == CTDP_ST_EXEC);
  wire last_cyc = in_exec & (cycles_left == 4'h1);
  wire take = instr_ready_o & instr_start_i;

  // A new instruction may follow the last cycle of the previous one
  assign instr_ready_o = cyc_end & ((state == CTDP_ST_IDLE) | last_cyc);
  assign instr_done_o = cyc_end & last_cyc;
  assign instr_busy_o = in_exec;
  assign cycle_strobe_o = cyc_end;
  assign phase_o = phase;

  always_comb begin
    next_state = state;
    next_cycles_left = cycles_left;
    unique case (state)
      CTDP_ST_IDLE: begin
        if (take) begin
          next_state = CTDP_ST_EXEC;
          next_cycles_left = req_cyc;
        end
      end
      CTDP_ST_EXEC: begin
        if (cyc_end) begin
          if (cycles_left != 4'h1) begin
            next_cycles_left = cycles_left - 4'h1;
          end else if (take) begin
            next_cycles_left = req_cyc;
          end else begin
            next_state = CTDP_ST_IDLE;
            next_cycles_left = 4'h0;
          end
        end
      end
      default: begin
        next_state = CTDP_ST_IDLE;
        next_cycles_left = 4'h0;
      end
    endcase
  end

  // Free-running phase keeps instruction cycles on a fixed grid
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= cyc_end ? 2'h0 : phase + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= CTDP_ST_IDLE;
      cycles_left <= 4'h0;
    end else begin
      state <= next_state;
      cycles_left <= next_cycles_left;
    end
  end

  // Pointer update: core operation first, register writes override
  wire [15:0] first_ptr = {first_pointer_high, first_pointer_low};
  wire [15:0] second_ptr = {second_pointer_high, second_pointer_low};
  wire [15:0] sel_ptr = pointer_select ? second_ptr : first_ptr;
  wire ptr_load = (ptr_op_i == CTDP_PTR_LOAD);
  wire ptr_inc = (ptr_op_i == CTDP_PTR_INC);
  wire ptr_idx = (ptr_op_i == CTDP_PTR_INDEX);
  wire [15:0] ptr_new = ptr_load ? ptr_load_i : sel_ptr + 16'h0001;

  always_comb begin
    next_first = first_ptr;
    next_second = second_ptr;
    next_sel = pointer_select;
    if (ptr_load | ptr_inc) begin
      if (pointer_select) begin
        next_second = ptr_new;
      end else begin
        next_first = ptr_new;
      end
    end
    if (wr_pa_lo) begin
      next_first[7:0] = sfr_wdata_i;
    end
    if (wr_pa_hi) begin
      next_first[15:8] = sfr_wdata_i;
    end
    if (wr_pb_lo) begin
      next_second[7:0] = sfr_wdata_i;
    end
    if (wr_pb_hi) begin
      next_second[15:8] = sfr_wdata_i;
    end
    // A write to the select register keeps only bit 0 of the written data
    if (wr_sel) begin
      next_sel = sfr_wdata_i[`CTDP_SEL_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      first_pointer_low <= `CTDP_RST_ZERO;
      first_pointer_high <= `CTDP_RST_ZERO;
      second_pointer_low <= `CTDP_RST_ZERO;
      second_pointer_high <= `CTDP_RST_ZERO;
      pointer_select <= 1'b0;
      active_data_pointer_o <= 16'h0000;
    end else begin
      first_pointer_low <= next_first[7:0];
      first_pointer_high <= next_first[15:8];
      second_pointer_low <= next_second[7:0];
      second_pointer_high <= next_second[15:8];
      pointer_select <= next_sel;
      // Registered so the address stays stable through the access
      active_data_pointer_o <= next_sel ? next_second : next_first;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      index_addr_o <= 16'h0000;
    end else if (ptr_idx) begin
      index_addr_o <= sel_ptr + {8'h00, acc_i};
    end
  end

  // General registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      port0_latch <= `CTDP_RST_PORT0;
      stack_pointer <= `CTDP_RST_SP;
      power_control <= `CTDP_RST_POWER_CONTROL;
      timer_control <= `CTDP_RST_ZERO;
      timer_mode_select <= `CTDP_RST_ZERO;
    end else begin
      if (wr_port0) port0_latch <= sfr_wdata_i;
      if (wr_sp) stack_pointer <= sfr_wdata_i;
      // Spare bit 6 is stored and reaches both power_control_o and the register read data
      if (wr_power_control) power_control <= sfr_wdata_i | `CTDP_POWER_CONTROL_ONES;
      if (wr_timer_control) timer_control <= sfr_wdata_i;
      if (wr_timer_mode_select) timer_mode_select <= sfr_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      timer_a_count_low <= `CTDP_RST_ZERO;
      timer_b_count_low <= `CTDP_RST_ZERO;
      timer_a_count_high <= `CTDP_RST_ZERO;
      timer_b_count_high <= `CTDP_RST_ZERO;
    end else begin
      if (wr_ta_lo) timer_a_count_low <= sfr_wdata_i;
      if (wr_tb_lo) timer_b_count_low <= sfr_wdata_i;
      if (wr_ta_hi) timer_a_count_high <= sfr_wdata_i;
      if (wr_tb_hi) timer_b_count_high <= sfr_wdata_i;
    end
  end

  // Bits 7:6 are spare: stored, read back, no effect
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      clock_rate_control <= `CTDP_RST_CLOCK_RATE_CONTROL;
    end else if (wr_clock_rate_control) begin
      clock_rate_control <= sfr_wdata_i;
    end
  end

  // Read data answers one clock after the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= read_mux;
    end
  end

  assign port0_latch_o = port0_latch;
  assign stack_pointer_o = stack_pointer;
  assign power_control_o = power_control_view;
  assign timer_control_o = timer_control;
  assign timer_mode_select_o = timer_mode_select;

  // Timer increment rate per timer
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_rate
      ctdp_rate_div #(
        .SLOW(SLOW_DIV),
        .FAST(FAST_DIV)
      ) u_div (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .fast_i(rate_bits[g]),
        .tick_o(timer_tick_o[g])
      );
    end
  endgenerate

endmodule : ctdp_core

`default_nettype wire

// [verification/ctdp_core_properties.sv]
`include "ctdp_params.svh"
`timescale 1ns/10ps
`default_nettype none

module ctdp_core_properties
  import ctdp_pkg::*;
#(
  parameter int NUM_TIMERS = 3
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register access
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  // Instruction timing
  input wire logic instr_start_i,
  input wire ctdp_class_t instr_class_i,
  input wire logic [2:0] instr_bytes_i,
  input wire logic instr_ready_o,
  input wire logic instr_done_o,
  input wire logic cycle_strobe_o,
  // Pointer operations
  input wire ctdp_ptr_op_t ptr_op_i,
  input wire logic [15:0] ptr_load_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] active_data_pointer_o,
  input wire logic [15:0] index_addr_o,
  // Timer strobes
  input wire logic [NUM_TIMERS-1:0] timer_tick_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  wire logic take = instr_start_i && instr_ready_o;

  sequence s_take_bytes(n);
    take && instr_class_i == CTDP_CLS_BYTES && instr_bytes_i == n;
  endsequence
  sequence s_done_in_four;
    !instr_done_o [*3] ##1 instr_done_o;
  endsequence

  a_cycle_four_clk: assert property (cycle_strobe_o |=> !cycle_strobe_o [*3] ##1 cycle_strobe_o)
    else $error("instruction cycle is not four clocks");
  a_done_on_boundary: assert property (instr_done_o |-> cycle_strobe_o)
    else $error("instruction ends inside a cycle");
  a_one_byte_time: assert property (s_take_bytes(1) |=> s_done_in_four)
    else $error("one byte instruction not one cycle");
  a_three_byte_time: assert property (s_take_bytes(3) |-> ##12 instr_done_o)
    else $error("three byte instruction not twelve clocks");
  a_muldiv_time: assert property (take && instr_class_i == CTDP_CLS_MULDIV |->
    ##20 instr_done_o)
    else $error("multiply or divide not five cycles");
  a_tick_min_gap: assert property (timer_tick_o[0] |=> !timer_tick_o[0] [*3])
    else $error("timer strobes closer than four clocks");
  a_tick_after_rst: assert property ($fell(sys_rst_i) |-> !(|timer_tick_o) [*8])
    else $error("timer strobe too early after reset");
  a_ptr_load_val: assert property (ptr_op_i == CTDP_PTR_LOAD && !sfr_wr_i |=>
    active_data_pointer_o == $past(ptr_load_i))
    else $error("pointer load lost");
  a_ptr_inc_val: assert property (ptr_op_i == CTDP_PTR_INC && !sfr_wr_i |=>
    active_data_pointer_o == $past(active_data_pointer_o) + 16'h0001)
    else $error("pointer increment wrong");
  a_index_sum: assert property (ptr_op_i == CTDP_PTR_INDEX && !sfr_wr_i |=>
    index_addr_o == $past(active_data_pointer_o) + 16'($past(acc_i)))
    else $error("indexed address wrong");
  a_sel_unused_zero: assert property (sfr_rd_i && sfr_addr_i == `CTDP_ADDR_SEL |=>
    sfr_rdata_o[7:1] == 7'h00)
    else $error("select register upper bits not zero");
  a_power_control_fixed_ones: assert property (sfr_rd_i && sfr_addr_i == `CTDP_ADDR_POWER_CONTROL |=>
    sfr_rdata_o[5:4] == 2'h3)
    else $error("fixed ones not read back");
endmodule : ctdp_core_properties

bind ctdp_core ctdp_core_properties #(.NUM_TIMERS(NUM_TIMERS)) i_props (.clk_sys_i, .sys_rst_i,
  .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .instr_start_i, .instr_class_i,
  .instr_bytes_i, .instr_ready_o, .instr_done_o, .cycle_strobe_o, .ptr_op_i, .ptr_load_i,
  .acc_i, .active_data_pointer_o, .index_addr_o, .timer_tick_o);

`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ctdp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] acc_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic instr_start_i = 1'b0;
  ctdp_class_t instr_class_i = CTDP_CLS_BYTES;
  logic [2:0] instr_bytes_i = 3'h1;
  ctdp_ptr_op_t ptr_op_i = CTDP_PTR_NONE;
  logic [15:0] ptr_load_i = 16'h0000;
  logic [7:0] sfr_rdata_o, port0_latch_o, stack_pointer_o, power_control_o;
  logic [7:0] timer_control_o, timer_mode_select_o, v, lo0, hi0, lo1, hi1;
  logic sfr_hit_o, instr_ready_o, instr_done_o, instr_busy_o, cycle_strobe_o;
  logic [1:0] phase_o;
  logic [15:0] active_data_pointer_o, index_addr_o;
  logic [2:0] timer_tick_o;
  integer seed = 32'h2a35ab8a;
  integer error_cnt = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer n;

  ctdp_core i_dut (.clk_sys_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .sfr_hit_o, .instr_start_i, .instr_class_i, .instr_bytes_i, .instr_ready_o,
    .instr_done_o, .instr_busy_o, .cycle_strobe_o, .phase_o, .ptr_op_i, .ptr_load_i, .acc_i,
    .active_data_pointer_o, .index_addr_o, .timer_tick_o, .port0_latch_o, .stack_pointer_o,
    .power_control_o, .timer_control_o, .timer_mode_select_o);

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // A hang anywhere ends the run through the same report
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      final_report;
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] rst_val(input logic [7:0] a);
    return a == 8'h80 ? 8'hFF : a == 8'h81 ? 8'h07 : a == 8'h87 ? 8'h30 :
      a == 8'h8E ? 8'h01 : 8'h00;
  endfunction : rst_val

  function automatic logic [7:0] rd_val(input logic [7:0] a, input logic [7:0] d);
    return a == 8'h86 ? (d & 8'h01) : a == 8'h87 ? (d | 8'h30) : a == 8'h8F ? 8'h00 : d;
  endfunction : rd_val

  // Strobes drop for a full cycle so back-to-back calls never retouch them in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
    @(negedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
    check("register read", {8'h00, sfr_rdata_o}, {8'h00, exp});
    check("address hit", {15'h0000, sfr_hit_o}, {15'h0000, (a >= 8'h80 && a <= 8'h8E)});
    @(negedge clk_sys_i);
  endtask : rd

  task automatic ptr(input ctdp_ptr_op_t op, input logic [15:0] ld, input logic [7:0] ac);
    ptr_op_i = op;
    ptr_load_i = ld;
    acc_i = ac;
    @(negedge clk_sys_i);
    ptr_op_i = CTDP_PTR_NONE;
    @(negedge clk_sys_i);
  endtask : ptr

  task automatic instr(input ctdp_class_t c, input logic [2:0] b, input integer exp);
    n = 0;
    while (instr_ready_o !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    instr_class_i = c;
    instr_bytes_i = b;
    instr_start_i = 1'b1;
    @(negedge clk_sys_i);
    instr_start_i = 1'b0;
    n = 1;
    while (instr_done_o !== 1'b1 && n < 60) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("instruction clocks", 16'(n), 16'(exp));
  endtask : instr

  task automatic gap(input integer g, input integer exp);
    n = 0;
    while (timer_tick_o[g] !== 1'b1 && n < 30) begin
      @(negedge clk_sys_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (timer_tick_o[g] !== 1'b1 && n < 30);
    check("tick spacing", 16'(n), 16'(exp));
  endtask : gap

  initial begin
    repeat (10) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (timer_tick_o[0] !== 1'b1 && n < 30);
    check("first tick", 16'(n), 16'd12);
    check("pointer after reset", active_data_pointer_o, 16'h0000);
    for (int a = 8'h80; a <= 8'h8F; a++) rd(a[7:0], rst_val(a[7:0]));
    // Reserved address 0x8F is only read, never written
    for (int a = 8'h80; a <= 8'h8E; a++) begin
      v = 8'($random(seed));
      wr(a[7:0], v);
      rd(a[7:0], rd_val(a[7:0], v));
    end
    rd(8'h8F, 8'h00);
    lo0 = 8'($random(seed));
    hi0 = 8'($random(seed));
    lo1 = 8'($random(seed));
    hi1 = 8'($random(seed));
    wr(8'h82, lo0);
    wr(8'h83, hi0);
    wr(8'h84, lo1);
    wr(8'h85, hi1);
    wr(8'h86, 8'h00);
    check("first pointer", active_data_pointer_o, {hi0, lo0});
    wr(8'h86, 8'hFF);
    check("second pointer", active_data_pointer_o, {hi1, lo1});
    wr(8'h86, 8'h01 + 8'h01);
    check("toggled pointer", active_data_pointer_o, {hi0, lo0});
    rd(8'h86, 8'h00);
    wr(8'h86, 8'h01);
    ptr(CTDP_PTR_LOAD, 16'hFFFF, 8'h00);
    rd(8'h84, 8'hFF);
    rd(8'h82, lo0);
    ptr(CTDP_PTR_INC, 16'h0000, 8'h00);
    check("wrapped pointer", active_data_pointer_o, 16'h0000);
    ptr(CTDP_PTR_LOAD, {lo1, hi1}, 8'h00);
    v = 8'($random(seed));
    ptr(CTDP_PTR_INDEX, 16'h0000, v);
    check("indexed address", index_addr_o, {lo1, hi1} + {8'h00, v});
    wr(8'h8E, 8'h01);
    for (int b = 1; b <= 5; b++) instr(CTDP_CLS_BYTES, b[2:0], 4 * b);
    instr(CTDP_CLS_MULDIV, 3'h1, 20);
    for (int s = 0; s < 8; s++) begin
      wr(8'h8E, s[7:0]);
      instr(CTDP_CLS_XMOVE, 3'h1, 4 * (2 + s));
    end
    for (int g = 0; g < 3; g++) begin
      wr(8'h8E, 8'h08 << g);
      gap(g, 4);
      wr(8'h8E, 8'h00);
      gap(g, 12);
    end
    final_report;
  end
endmodule : tb

`default_nettype wire
